//--- hdl/jao_pkg.sv
package jao_pkg;
    // Axis and port counts
    localparam int NUM_AXES      = 4;
    localparam int NUM_CFG_PORTS = 4;
    localparam int NUM_IN_PORTS  = 3;
    localparam int NUM_PORTS     = 7;
    localparam int NUM_CURVES    = 7;
    localparam int NUM_PTS       = 5;
    localparam int POS_W         = 10;
    localparam int CUR_W         = 12;
    // Clock and timing
    localparam int CLK_HZ        = 25000000;
    localparam int RAMP_STEP_US  = 25600;
    localparam int RAMP_STEP_CYC = CLK_HZ / 1000000 * RAMP_STEP_US;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int DM_TMO_S_DEF  = 60;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_PORTFN   = 8'h04;
    localparam logic [7:0] ADDR_DEADBAND = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_CURVE0   = 8'h40;
    // Per-curve word offsets (curve n at ADDR_CURVE0 + 16*n)
    localparam logic [3:0] CW_SEL  = 4'h0;
    localparam logic [3:0] CW_Y01  = 4'h4;
    localparam logic [3:0] CW_Y23  = 4'h8;
    localparam logic [3:0] CW_Y4R  = 4'hc;
    // Control register fields
    localparam int CTRL_DM_WDG   = 0;
    localparam int CTRL_STA_RTW  = 1;
    localparam int CTRL_SEC_EN   = 2;
    localparam int CTRL_FAULT    = 3;
    localparam int CTRL_TMO_LSB  = 8;
    localparam int CTRL_TMO_W    = 6;
    localparam logic [31:0] CTRL_RST = 32'h00003c00;
    // Neutral dead band default percent
    localparam logic [7:0] DEADBAND_RST = 8'h08;
    // Port functions (4 bits each)
    localparam logic [3:0] FN_NONE   = 4'h0;
    localparam logic [3:0] FN_DMAN   = 4'h1;
    localparam logic [3:0] FN_FC1    = 4'h2;
    localparam logic [3:0] FN_FC2    = 4'h3;
    localparam logic [3:0] FN_FCA    = 4'h4;
    localparam logic [3:0] FN_A1P    = 4'h8;
    localparam logic [3:0] FN_A1M    = 4'h9;
    localparam logic [3:0] FN_A2P    = 4'ha;
    localparam logic [3:0] FN_A2M    = 4'hb;
    localparam logic [3:0] FN_OC1    = 4'hc;
    localparam logic [3:0] FN_OC2    = 4'hd;
    localparam logic [3:0] FN_STA    = 4'he;
    // Fixed curve abscissae (percent of travel)
    localparam logic [6:0] X_PT0 = 7'd8;
    localparam logic [6:0] X_PT1 = 7'd33;
    localparam logic [6:0] X_PT2 = 7'd66;
    localparam logic [6:0] X_PT3 = 7'd85;
    localparam logic [6:0] X_PT4 = 7'd100;
endpackage

//--- hdl/jao_ramp_if.sv
`timescale 1ns/100ps
interface jao_ramp_if #(parameter int CUR_W = 12);
    logic [CUR_W-1:0] target;
    logic [7:0]       up_steps;
    logic [7:0]       dn_steps;
    logic             bypass;
    logic             tick;
    logic [CUR_W-1:0] level;
    modport src (output target, up_steps, dn_steps, bypass, tick, input level);
    modport rmp (input target, up_steps, dn_steps, bypass, tick, output level);
endinterface

//--- hdl/jao_ramp.sv
`timescale 1ns/100ps
module jao_ramp #(
    parameter int CUR_W = 12
) (
    input  wire logic clk_i,      // System clock
    input  wire logic rst_i,      // Synchronous reset
    jao_ramp_if.rmp   rp          // Ramp request and level
);
    import jao_pkg::*;
    // Full scale step per tick: span / steps plus one, whole span when steps is zero
    localparam int FULL = (1 << CUR_W) - 1;
    logic [CUR_W-1:0] level_reg;
    logic [CUR_W-1:0] up_inc;
    logic [CUR_W-1:0] dn_inc;
    logic [CUR_W:0]   up_sum;
    logic [CUR_W:0]   dn_dif;
    logic [CUR_W-1:0] level_next;
    assign up_inc = (rp.up_steps == 8'h00) ? CUR_W'(FULL) : CUR_W'(FULL / rp.up_steps + 1);
    assign dn_inc = (rp.dn_steps == 8'h00) ? CUR_W'(FULL) : CUR_W'(FULL / rp.dn_steps + 1);
    assign up_sum = {1'b0, level_reg} + {1'b0, up_inc};
    assign dn_dif = {1'b0, level_reg} - {1'b0, dn_inc};
    assign level_next = rp.bypass ? rp.target :
                        !rp.tick ? level_reg :
                        (rp.target > level_reg) ?
                            ((up_sum[CUR_W] || up_sum[CUR_W-1:0] > rp.target) ? rp.target : up_sum[CUR_W-1:0]) :
                        (rp.target < level_reg) ?
                            ((dn_dif[CUR_W] || dn_dif[CUR_W-1:0] < rp.target) ? rp.target : dn_dif[CUR_W-1:0]) :
                        level_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= '0;
        end else begin
            level_reg <= level_next;
        end
    end
    assign rp.level = level_reg;
    bypass_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rp.bypass |=> level_reg == $past(rp.target)) else $error("bypass did not jump");
    ramp_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rp.bypass && !rp.tick |=> $stable(level_reg)) else $error("level moved without tick");
endmodule // jao_ramp

//--- hdl/jao_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Direction output active outside neutral dead band
// - Six direction and off-center modes per port
// - Off-center active on either deflection
// - Fault lamp mode lights on fault
// - Healthy lamp mode lights without fault
// - Grounded input active, open inactive
// - Four bidirectional ports, three input-only
// - No operator presence forces current outputs neutral
// - Presence change skips the ramps
// - Permanent mode needs input held grounded
// - Watchdog mode needs periodic input toggling
// - Watchdog timeout zero to 63 seconds, sixty by default
// - Fine input grounded selects fine curves
// - Curve set changes at any position
// - Five-point curve from position to current
// - Separate rise and fall ramp times
// - Ramp full span, 25.6 ms steps
// - Default curve linear minimum to maximum
// - Special curve points percent of maximum
// - Up to seven special curves
// - Secondary outputs mirror axes 1,2 onto 3,4
module jao_top
    import jao_pkg::*;
#(
    parameter int RAMP_CYC = RAMP_STEP_CYC,
    parameter int TICK_C   = TICK_CYC
) (
    input  wire logic                          clk_i,     // 25 MHz clock
    input  wire logic                          rst_i,     // Synchronous reset
    input  wire logic [31:0]                   wb_adr_i,  // Wishbone address
    input  wire logic [31:0]                   wb_dat_i,  // Wishbone write data
    output logic      [31:0]                   wb_dat_o,  // Wishbone read data
    input  wire logic [3:0]                    wb_sel_i,  // Byte enables
    input  wire logic                          wb_we_i,   // Write enable
    input  wire logic                          wb_cyc_i,  // Cycle
    input  wire logic                          wb_stb_i,  // Strobe
    output logic                               wb_ack_o,  // Acknowledge
    input  wire logic [jao_pkg::NUM_AXES*jao_pkg::POS_W-1:0] pos_i, // Signed axis positions
    input  wire logic [jao_pkg::NUM_AXES*2*jao_pkg::CUR_W-1:0] cur_min_i, // Min current per out
    input  wire logic [jao_pkg::NUM_AXES*2*jao_pkg::CUR_W-1:0] cur_max_i, // Max current per out
    input  wire logic                          fault_i,   // Fault detected elsewhere
    input  wire logic [jao_pkg::NUM_PORTS-1:0] port_pin_i,// Port pin levels, pulled up
    output logic [jao_pkg::NUM_CFG_PORTS-1:0]  port_o,    // Port drive level
    output logic [jao_pkg::NUM_CFG_PORTS-1:0]  port_oe_o, // Port drive enable
    output logic [jao_pkg::NUM_AXES*2*jao_pkg::CUR_W-1:0] cur_o, // Solenoid current set points
    output logic                               enabled_o  // Operator presence granted
);
    import jao_pkg::*;
    localparam int NOUT = NUM_AXES * 2;

    // ****************************************
    // Registers and bus
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [27:0] portfn_reg;
    logic [7:0]  deadband_reg;
    logic [31:0] curve_sel_reg [NUM_CURVES];
    logic [31:0] curve_y01_reg [NUM_CURVES];
    logic [31:0] curve_y23_reg [NUM_CURVES];
    logic [31:0] curve_y4r_reg [NUM_CURVES];
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] status_w;
    logic [31:0] rdat_next;
    logic        wb_req;
    logic        wr_en;
    logic [7:0]  adr8;
    logic [2:0]  cidx;
    logic        curve_hit;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                old[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return old;
    endfunction

    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_en     = wb_req && wb_we_i;
    assign adr8      = wb_adr_i[7:0];
    assign cidx      = 3'((adr8 - ADDR_CURVE0) >> 4);
    assign curve_hit = (adr8 >= ADDR_CURVE0) && (adr8 < ADDR_CURVE0 + 8'(16*NUM_CURVES)) && (wb_adr_i[31:8] == '0);

    always_comb begin
        rdat_next = 32'h00000000;
        if (wb_adr_i[31:8] == '0) begin
            case (adr8)
                ADDR_CTRL:     rdat_next = ctrl_reg;
                ADDR_PORTFN:   rdat_next = {4'h0, portfn_reg};
                ADDR_DEADBAND: rdat_next = {24'h000000, deadband_reg};
                ADDR_STATUS:   rdat_next = status_w;
                default: begin
                    if (curve_hit) begin
                        case (adr8[3:0])
                            CW_SEL:  rdat_next = curve_sel_reg[cidx];
                            CW_Y01:  rdat_next = curve_y01_reg[cidx];
                            CW_Y23:  rdat_next = curve_y23_reg[cidx];
                            CW_Y4R:  rdat_next = curve_y4r_reg[cidx];
                            default: rdat_next = 32'h00000000;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg      <= 1'b0;
            rdat_reg     <= 32'h00000000;
            ctrl_reg     <= CTRL_RST;
            portfn_reg   <= '0;
            deadband_reg <= DEADBAND_RST;
            for (int c = 0; c < NUM_CURVES; c++) begin
                curve_sel_reg[c] <= 32'h00000000;
                curve_y01_reg[c] <= 32'h00000000;
                curve_y23_reg[c] <= 32'h00000000;
                curve_y4r_reg[c] <= 32'h00000000;
            end
        end else begin
            ack_reg  <= wb_req;
            rdat_reg <= rdat_next;
            if (wr_en && wb_adr_i[31:8] == '0) begin
                if (adr8 == ADDR_CTRL)     ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
                if (adr8 == ADDR_PORTFN)   portfn_reg <= 28'(merge({4'h0, portfn_reg}, wb_dat_i, wb_sel_i));
                if (adr8 == ADDR_DEADBAND) deadband_reg <= 8'(merge({24'h0, deadband_reg}, wb_dat_i, wb_sel_i));
                if (curve_hit && adr8[3:0] == CW_SEL) curve_sel_reg[cidx] <= merge(curve_sel_reg[cidx], wb_dat_i, wb_sel_i);
                if (curve_hit && adr8[3:0] == CW_Y01) curve_y01_reg[cidx] <= merge(curve_y01_reg[cidx], wb_dat_i, wb_sel_i);
                if (curve_hit && adr8[3:0] == CW_Y23) curve_y23_reg[cidx] <= merge(curve_y23_reg[cidx], wb_dat_i, wb_sel_i);
                if (curve_hit && adr8[3:0] == CW_Y4R) curve_y4r_reg[cidx] <= merge(curve_y4r_reg[cidx], wb_dat_i, wb_sel_i);
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ****************************************
    // Pin inputs and port functions
    // ****************************************
    logic [NUM_PORTS-1:0] pin_s1_reg;
    logic [NUM_PORTS-1:0] pin_s2_reg;
    logic [NUM_PORTS-1:0] act_w;
    logic [3:0]           fn_w [NUM_PORTS];
    logic                 dman_cfg, dman_act, fc1_act, fc2_act;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
        end else begin
            pin_s1_reg <= port_pin_i;
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign act_w = ~pin_s2_reg;
    always_comb begin
        dman_cfg = 1'b0;
        dman_act = 1'b0;
        fc1_act  = 1'b0;
        fc2_act  = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (fn_w[p] == FN_DMAN) begin
                dman_cfg = 1'b1;
                dman_act = dman_act | act_w[p];
            end
            if ((fn_w[p] == FN_FC1 || fn_w[p] == FN_FCA) && act_w[p]) fc1_act = 1'b1;
            if ((fn_w[p] == FN_FC2 || fn_w[p] == FN_FCA) && act_w[p]) fc2_act = 1'b1;
        end
    end
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_fn
            assign fn_w[gp] = portfn_reg[4*gp +: 4];
        end
    endgenerate

    // ****************************************
    // Operator presence
    // ****************************************
    logic        tick_ms_reg;
    logic [$clog2(TICK_C+1)-1:0] tick_cnt_reg;
    logic [15:0] wdg_cnt_reg;
    logic        dm_prev_reg;
    logic        en_reg;
    logic        en_next;
    logic [15:0] tmo_ms;
    assign tmo_ms = 16'(ctrl_reg[CTRL_TMO_LSB +: CTRL_TMO_W]) * 16'd1000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= '0;
            tick_ms_reg  <= 1'b0;
            wdg_cnt_reg  <= '0;
            dm_prev_reg  <= 1'b0;
            en_reg       <= 1'b0;
        end else begin
            tick_ms_reg  <= (tick_cnt_reg == $bits(tick_cnt_reg)'(TICK_C - 1));
            tick_cnt_reg <= (tick_cnt_reg == $bits(tick_cnt_reg)'(TICK_C - 1)) ? '0 : tick_cnt_reg + 1'b1;
            dm_prev_reg  <= dman_act;
            if (dman_act != dm_prev_reg) wdg_cnt_reg <= '0;
            else if (tick_ms_reg && wdg_cnt_reg != 16'hffff) wdg_cnt_reg <= wdg_cnt_reg + 16'd1;
            en_reg <= en_next;
        end
    end
    assign en_next = !dman_cfg ? 1'b1 :
                     ctrl_reg[CTRL_DM_WDG] ? ((dman_act != dm_prev_reg) || (wdg_cnt_reg < tmo_ms)) :
                     dman_act;
    assign enabled_o = en_reg;

    // ****************************************
    // Axis mapping and curves
    // ****************************************
    logic        ramp_tick_reg;
    logic [$clog2(RAMP_CYC+1)-1:0] ramp_cnt_reg;
    logic        en_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_cnt_reg  <= '0;
            ramp_tick_reg <= 1'b0;
            en_d_reg      <= 1'b0;
        end else begin
            ramp_tick_reg <= (ramp_cnt_reg == $bits(ramp_cnt_reg)'(RAMP_CYC - 1));
            ramp_cnt_reg  <= (ramp_cnt_reg == $bits(ramp_cnt_reg)'(RAMP_CYC - 1)) ? '0 : ramp_cnt_reg + 1'b1;
            en_d_reg      <= en_reg;
        end
    end

    logic [6:0] pct_w  [NUM_AXES];
    logic       plus_w [NUM_AXES];
    logic       oc_w   [NUM_AXES];
    logic [CUR_W-1:0] out_q [NOUT];
    genvar ga, go;
    generate
        for (ga = 0; ga < NUM_AXES; ga++) begin : g_axis
            logic signed [POS_W-1:0] p;
            logic [POS_W-1:0]        mag;
            assign p = (ctrl_reg[CTRL_SEC_EN] && ga >= 2) ? pos_i[(ga % 2)*POS_W +: POS_W] : pos_i[ga*POS_W +: POS_W];
            assign mag     = p[POS_W-1] ? POS_W'(-p) : POS_W'(p);
            assign pct_w[ga]  = (mag >= POS_W'(511)) ? 7'd100 : 7'((32'(mag) * 100) / 511);
            assign plus_w[ga] = !p[POS_W-1];
            assign oc_w[ga]   = {1'b0, pct_w[ga]} > deadband_reg;
        end
        for (go = 0; go < NOUT; go++) begin : g_out
            localparam int AX = go / 2;
            localparam bit MINUS = (go % 2) == 1;
            logic [CUR_W-1:0] cmin, cmax, lin, tgt, spec;
            logic [7:0] y [NUM_PTS];
            logic [7:0] rup, rdn;
            logic       hit;
            logic [2:0] hsel;
            logic       fine;
            logic [6:0] x;
            logic [31:0] yv;
            jao_ramp_if #(.CUR_W(CUR_W)) rif ();
            assign cmin = cur_min_i[go*CUR_W +: CUR_W];
            assign cmax = cur_max_i[go*CUR_W +: CUR_W];
            assign x    = (pct_w[AX] < X_PT0) ? X_PT0 : pct_w[AX];
            assign fine = (AX % 2 == 0) ? fc1_act : fc2_act;
            always_comb begin
                hit  = 1'b0;
                hsel = 3'd0;
                for (int c = NUM_CURVES - 1; c >= 0; c--) begin
                    if (curve_sel_reg[c][0] && curve_sel_reg[c][3:2] == 2'(AX) &&
                        curve_sel_reg[c][1] == MINUS && curve_sel_reg[c][4] == fine) begin
                        hit  = 1'b1;
                        hsel = 3'(c);
                    end
                end
            end
            assign y[0] = curve_y01_reg[hsel][7:0];
            assign y[1] = curve_y01_reg[hsel][15:8];
            assign y[2] = curve_y23_reg[hsel][7:0];
            assign y[3] = curve_y23_reg[hsel][15:8];
            assign y[4] = curve_y4r_reg[hsel][7:0];
            assign rup  = curve_y4r_reg[hsel][15:8];
            assign rdn  = curve_y4r_reg[hsel][23:16];
            assign lin = CUR_W'(32'(cmin) + (32'(cmax - cmin) * 32'(x - X_PT0)) / 32'(X_PT4 - X_PT0));
            always_comb begin
                yv = 32'(y[4]) * 32'(cmax) / 100;
                if (x < X_PT1)      yv = (32'(y[0]) * 32'(X_PT1 - x) + 32'(y[1]) * 32'(x - X_PT0)) * 32'(cmax) / (100 * 32'(X_PT1 - X_PT0));
                else if (x < X_PT2) yv = (32'(y[1]) * 32'(X_PT2 - x) + 32'(y[2]) * 32'(x - X_PT1)) * 32'(cmax) / (100 * 32'(X_PT2 - X_PT1));
                else if (x < X_PT3) yv = (32'(y[2]) * 32'(X_PT3 - x) + 32'(y[3]) * 32'(x - X_PT2)) * 32'(cmax) / (100 * 32'(X_PT3 - X_PT2));
                else if (x < X_PT4) yv = (32'(y[3]) * 32'(X_PT4 - x) + 32'(y[4]) * 32'(x - X_PT3)) * 32'(cmax) / (100 * 32'(X_PT4 - X_PT3));
            end
            assign spec = (yv > 32'(cmax)) ? cmax : CUR_W'(yv);
            assign tgt  = (!en_reg || !oc_w[AX] || plus_w[AX] == MINUS) ? '0 : (hit ? spec : lin);
            assign rif.target   = tgt;
            assign rif.up_steps = hit ? rup : 8'h00;
            assign rif.dn_steps = hit ? rdn : 8'h00;
            assign rif.bypass   = (en_reg != en_d_reg) || !en_reg;
            assign rif.tick     = ramp_tick_reg;
            jao_ramp #(.CUR_W(CUR_W)) u_ramp (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .rp    (rif)
            );
            assign out_q[go] = rif.level;
        end
    endgenerate

    // ****************************************
    // Port outputs
    // ****************************************
    logic [NUM_CFG_PORTS-1:0] drv_next, oe_next;
    logic [NUM_CFG_PORTS-1:0] drv_reg, oe_reg;
    logic [NOUT*CUR_W-1:0]    cur_reg;
    always_comb begin
        for (int p = 0; p < NUM_CFG_PORTS; p++) begin
            oe_next[p] = fn_w[p][3];
            case (fn_w[p])
                FN_A1P: drv_next[p] = oc_w[0] && plus_w[0];
                FN_A1M: drv_next[p] = oc_w[0] && !plus_w[0];
                FN_A2P: drv_next[p] = oc_w[1] && plus_w[1];
                FN_A2M: drv_next[p] = oc_w[1] && !plus_w[1];
                FN_OC1: drv_next[p] = oc_w[0];
                FN_OC2: drv_next[p] = oc_w[1];
                FN_STA: drv_next[p] = ctrl_reg[CTRL_STA_RTW] ? !fault_i : fault_i;
                default: drv_next[p] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_reg <= '0;
            oe_reg  <= '0;
            cur_reg <= '0;
        end else begin
            drv_reg <= drv_next;
            oe_reg  <= oe_next;
            for (int o = 0; o < NOUT; o++) cur_reg[o*CUR_W +: CUR_W] <= out_q[o];
        end
    end
    assign port_o    = drv_reg;
    assign port_oe_o = oe_reg;
    assign cur_o     = cur_reg;
    assign status_w  = {24'h0, 2'b00, fault_i, fc2_act, fc1_act, dman_act, en_reg, 1'b0};

    perm_neutral_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dman_cfg && !ctrl_reg[CTRL_DM_WDG] && !dman_act |=> !en_reg) else $error("presence kept without ground");
    neutral_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_reg ##1 !en_reg |=> cur_reg == '0) else $error("current while disabled");
    oc_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fn_w[0] == FN_OC1 |=> port_o[0] == $past(oc_w[0])) else $error("off-center port wrong");
    lamp_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fn_w[3] == FN_STA && !ctrl_reg[CTRL_STA_RTW] |=> port_o[3] == $past(fault_i)) else $error("fault lamp wrong");
    in_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> port_oe_o == $past(oe_next)) else $error("port enable wrong");
endmodule // jao_top

//--- verification/jao_field_model.sv
`timescale 1ns/100ps
module jao_field_model (
    input  wire logic                                    clk_i,   // Clock
    input  wire logic [jao_pkg::NUM_PORTS-1:0]           gnd_i,   // Switches closed
    input  wire logic                                    wdg_i,   // Operator toggles port 4
    input  wire logic [jao_pkg::NUM_AXES*jao_pkg::POS_W-1:0] stick_i, // Lever positions
    output logic      [jao_pkg::NUM_PORTS-1:0]           pin_o,   // Pin levels
    output logic      [jao_pkg::NUM_AXES*jao_pkg::POS_W-1:0] pos_o    // Sensor outputs
);
    import jao_pkg::*;
    logic [5:0] cnt_reg = 6'h00;
    logic       tog_reg = 1'h0;
    always_ff @(posedge clk_i) begin
        cnt_reg <= cnt_reg + 6'h01;
        if (cnt_reg == 6'h3f) tog_reg <= ~tog_reg;
    end
    assign pos_o = stick_i;
    assign pin_o = ~(gnd_i | {2'h0, wdg_i & tog_reg, 4'h0});
endmodule // jao_field_model

//--- verification/joystick_axis_output_functions_tb_top.sv
`timescale 1ns/100ps
module joystick_axis_output_functions_tb_top;
    import jao_pkg::*;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        we = 1'h0;
    logic        cs = 1'h0;
    logic        fault = 1'h0;
    logic        wdg = 1'h0;
    logic [6:0]  gnd = 7'h00;
    logic [39:0] stick = 40'h0;
    logic [39:0] pos;
    logic [6:0]  pin;
    logic [31:0] rdat, q;
    logic        ack, en;
    logic [3:0]  po, poe;
    logic [95:0] cur;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Rows: healthy mode, fault, axis2, axis1, expected ports
    localparam logic [25:0] ROWS [7] = '{{1'h0, 1'h0, 10'h000, 10'h000, 4'h0}, {1'h0, 1'h0, 10'h000, 10'h0c8, 4'h1},
        {1'h0, 1'h0, 10'h000, 10'h338, 4'h2}, {1'h0, 1'h1, 10'h338, 10'h000, 4'hc},
        {1'h0, 1'h0, 10'h032, 10'h01e, 4'h4}, {1'h1, 1'h1, 10'h000, 10'h000, 4'h0}, {1'h1, 1'h0, 10'h000, 10'h000, 4'h8}};
    jao_field_model fm (.clk_i(clk_i), .gnd_i(gnd), .wdg_i(wdg), .stick_i(stick), .pin_o(pin), .pos_o(pos));
    jao_top #(.RAMP_CYC(20), .TICK_C(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i({24'h0, adr}),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cs), .wb_stb_i(cs),
        .wb_ack_o(ack), .pos_i(pos), .cur_min_i({8{12'h100}}), .cur_max_i({8{12'h800}}), .fault_i(fault),
        .port_pin_i(pin), .port_o(po), .port_oe_o(poe), .cur_o(cur), .enabled_o(en));
    initial forever #20 clk_i = ~clk_i;
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        we <= w;
        cs <= 1'h1;
        do @(posedge clk_i); while (ack !== 1'h1);
        r = rdat;
        cs <= 1'h0;
        we <= 1'h0;
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(ADDR_CTRL, 1'h0, 32'h0, q);
        chk("ctrl", q, CTRL_RST);
        wb(ADDR_DEADBAND, 1'h0, 32'h0, q);
        chk("band", q, {24'h0, DEADBAND_RST});
        wb(8'h30, 1'h1, 32'hffffffff, q);
        wb(8'h30, 1'h0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        $display("test registers done");
        wb(ADDR_PORTFN, 1'h1, {16'h0, FN_STA, FN_OC2, FN_A1M, FN_A1P}, q);
        for (int i = 0; i < 7; i++) begin
            wb(ADDR_CTRL, 1'h1, CTRL_RST | {30'h0, ROWS[i][25], 1'h0}, q);
            fault <= ROWS[i][24];
            stick <= {20'h0, ROWS[i][23:4]};
            settle();
            chk("port", {28'h0, po}, {28'h0, ROWS[i][3:0]});
            chk("port_oe", {28'h0, poe}, 32'hf);
        end
        wb(ADDR_PORTFN, 1'h1, {16'h0, FN_STA, FN_A2M, FN_A2P, FN_OC1}, q);
        stick <= {20'h0, 10'h0c8, 10'h338};
        settle();
        chk("port_a2p", {28'h0, po}, 32'hb);
        stick <= {20'h0, 10'h338, 10'h000};
        settle();
        chk("port_a2m", {28'h0, po}, 32'hc);
        $display("test port functions done");
        wb(ADDR_PORTFN, 1'h1, {8'h0, FN_FC1, 20'h0}, q);
        wb(ADDR_CURVE0 | {4'h0, CW_SEL}, 1'h1, 32'h00000011, q);
        wb(ADDR_CURVE0 | {4'h0, CW_Y4R}, 1'h1, 32'h00100019, q);
        wb(ADDR_CURVE0 | {4'h0, CW_Y4R}, 1'h0, 32'h0, q);
        chk("curve_rd", q, 32'h00100019);
        wb(8'hcc, 1'h0, 32'h0, q);
        chk("curve_alias", q, 32'h0);
        stick <= 40'h1ff;
        repeat (30) @(posedge clk_i);
        chk("cur_normal", {20'h0, cur[11:0]}, 32'h800);
        gnd <= 7'h20;
        repeat (30) @(posedge clk_i);
        chk("cur_ramping", {31'h0, cur[11:0] > 12'h200}, 32'h1);
        wb(ADDR_STATUS, 1'h0, 32'h0, q);
        chk("status", q, 32'h0000000a);
        repeat (150) @(posedge clk_i);
        chk("cur_fine", {20'h0, cur[11:0]}, 32'h200);
        gnd <= 7'h00;
        repeat (30) @(posedge clk_i);
        chk("cur_back", {20'h0, cur[11:0]}, 32'h800);
        chk("cur_ax3_off", {20'h0, cur[59:48]}, 32'h0);
        wb(ADDR_CTRL, 1'h1, CTRL_RST | 32'h00000004, q);
        repeat (30) @(posedge clk_i);
        chk("cur_ax3_sec", {20'h0, cur[59:48]}, 32'h800);
        $display("test curves done");
        wb(ADDR_PORTFN, 1'h1, {12'h0, FN_DMAN, FN_STA, FN_OC2, FN_A1M, FN_A1P}, q);
        stick <= 40'h1ff;
        settle();
        chk("en_open", {31'h0, en}, 32'h0);
        chk("cur_open", cur[31:0], 32'h0);
        gnd <= 7'h10;
        settle();
        chk("en_held", {31'h0, en}, 32'h1);
        chk("cur_full", {20'h0, cur[11:0]}, 32'h800);
        gnd <= 7'h00;
        settle();
        chk("cur_drop", cur[31:0], 32'h0);
        $display("test presence done");
        wb(ADDR_CTRL, 1'h1, 32'h00000101, q);
        wdg <= 1'h1;
        repeat (10400) @(posedge clk_i);
        chk("wdg_on", {31'h0, en}, 32'h1);
        wdg <= 1'h0;
        repeat (10200) @(posedge clk_i);
        chk("wdg_off", {31'h0, en}, 32'h0);
        $display("test watchdog done");
        summarize();
    end
endmodule // joystick_axis_output_functions_tb_top
